// ==== hwfs_map.svh ====
`ifndef HWFS_MAP_SVH
`define HWFS_MAP_SVH

// ****************************************************************
// timing figures
// ****************************************************************
`define HWFS_CLK_MHZ     100
`define HWFS_WAKE_CYC    64
`define HWFS_FLASH_US    42
`define HWFS_POR_US      34
`define HWFS_FLASH_CYC   (`HWFS_FLASH_US * `HWFS_CLK_MHZ)
`define HWFS_POR_CYC     (`HWFS_POR_US * `HWFS_CLK_MHZ)
`define HWFS_CNT_W       13

// ****************************************************************
// reset values
// ****************************************************************
`define HWFS_RST_RUN     1'b0
`define HWFS_RST_RDY     1'b0
`define HWFS_RST_POR     1'b1
`define HWFS_RST_STOP    1'b0

`endif

// ==== hwfs_pkg.sv ====
`include "hwfs_map.svh"

package hwfs_pkg;

  typedef logic [`HWFS_CNT_W-1:0] hwfs_cnt_type;

  typedef enum logic [2:0] {
    hwfs_boot,
    hwfs_run,
    hwfs_halt,
    hwfs_ext,
    hwfs_wake,
    hwfs_por
  } hwfs_state_type;

endpackage

// ==== hwfs_tmr_if.sv ====
`timescale 1ns/1ps

interface hwfs_tmr_if;
  logic              ce;
  logic              start;
  logic              tick;
  hwfs_pkg::hwfs_cnt_type load;
  logic              done;

  modport ctl (output ce, output start, output tick, output load,
               input done);
  modport tmr (input ce, input start, input tick, input load,
               output done);
endinterface

// ==== hwfs_timer.sv ====
`timescale 1ns/1ps

module hwfs_timer (
  input  wire logic  i_core_clk,
  input  wire logic  i_rst,
  hwfs_tmr_if.tmr    t
);

  hwfs_pkg::hwfs_cnt_type cnt_r;

  // ****************************************************************
  // down counter, loaded by start, stepped by tick
  // ****************************************************************
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cnt_r <= '0;
    end else if (t.ce) begin
      if (t.start) begin
        cnt_r <= t.load;
      end else if (t.tick && cnt_r != '0) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  assign t.done = (cnt_r == '0) && !t.start;

endmodule

// ==== hwfs_sequencer.sv ====
`timescale 1ns/1ps
`include "hwfs_map.svh"

module hwfs_sequencer #(
  parameter int FLASH_CYC = `HWFS_FLASH_CYC,
  parameter int POR_CYC   = `HWFS_POR_CYC
) (
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  input  wire logic i_ce,
  input  wire logic i_cpu_tick,
  input  wire logic i_halt_req,
  input  wire logic i_wake,
  input  wire logic i_int_rst,
  input  wire logic i_ext_rst,
  output logic      o_cpu_run,
  output logic      o_flash_ready,
  output logic      o_clk_stopped
);

  hwfs_pkg::hwfs_state_type state_r;
  hwfs_pkg::hwfs_state_type state_nxt;
  logic                     por_r;
  logic                     wake_start;
  logic                     flash_start;
  hwfs_pkg::hwfs_cnt_type   flash_load;

  hwfs_tmr_if tif [2] ();

  // ****************************************************************
  // timers: 0 counts cpu ticks, 1 counts core cycles
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_tmr
      hwfs_timer u_tmr (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .t          (tif[gi])
      );
    end
  endgenerate

  assign tif[0].ce    = i_ce;
  assign tif[0].start = wake_start;
  assign tif[0].tick  = i_cpu_tick;
  assign tif[0].load  = `HWFS_CNT_W'(`HWFS_WAKE_CYC);
  assign tif[1].ce    = i_ce;
  assign tif[1].start = flash_start;
  assign tif[1].tick  = 1'b1;
  assign tif[1].load  = flash_load;

  // ****************************************************************
  // sequencing
  // ****************************************************************
  always_comb begin
    state_nxt   = state_r;
    wake_start  = 1'b0;
    flash_start = 1'b0;
    flash_load  = hwfs_pkg::hwfs_cnt_type'(FLASH_CYC);
    case (state_r)
      hwfs_pkg::hwfs_boot: begin
        wake_start = 1'b1;
        state_nxt  = hwfs_pkg::hwfs_wake;
      end
      hwfs_pkg::hwfs_run: begin
        if (i_int_rst || i_ext_rst) begin
          state_nxt = hwfs_pkg::hwfs_ext;
        end else if (i_halt_req) begin
          state_nxt = hwfs_pkg::hwfs_halt;
        end
      end
      hwfs_pkg::hwfs_halt: begin
        if (i_ext_rst) begin
          flash_start = 1'b1;
          state_nxt   = hwfs_pkg::hwfs_ext;
        end else if (i_wake) begin
          wake_start  = 1'b1;
          flash_start = 1'b1;
          state_nxt   = hwfs_pkg::hwfs_wake;
        end
      end
      hwfs_pkg::hwfs_ext: begin
        if (!i_ext_rst && !i_int_rst) begin
          wake_start = 1'b1;
          state_nxt  = hwfs_pkg::hwfs_wake;
        end
      end
      hwfs_pkg::hwfs_wake: begin
        if (tif[0].done && (o_flash_ready || por_r)) begin
          if (por_r) begin
            flash_start = 1'b1;
            flash_load  = hwfs_pkg::hwfs_cnt_type'(POR_CYC);
            state_nxt   = hwfs_pkg::hwfs_por;
          end else begin
            state_nxt = hwfs_pkg::hwfs_run;
          end
        end
      end
      hwfs_pkg::hwfs_por: begin
        if (tif[1].done) begin
          state_nxt = hwfs_pkg::hwfs_run;
        end
      end
      default: begin
        state_nxt = hwfs_pkg::hwfs_boot;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_r <= hwfs_pkg::hwfs_boot;
    end else if (i_ce) begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      por_r <= `HWFS_RST_POR;
    end else if (i_ce && state_r == hwfs_pkg::hwfs_por
                 && tif[1].done) begin
      por_r <= 1'b0;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_cpu_run <= `HWFS_RST_RUN;
    end else if (i_ce) begin
      o_cpu_run <= (state_nxt == hwfs_pkg::hwfs_run);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_clk_stopped <= `HWFS_RST_STOP;
    end else if (i_ce) begin
      o_clk_stopped <= (state_nxt == hwfs_pkg::hwfs_halt);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_flash_ready <= `HWFS_RST_RDY;
    end else if (i_ce) begin
      if (state_nxt == hwfs_pkg::hwfs_halt) begin
        o_flash_ready <= 1'b0;
      end else if (tif[1].done && (state_r == hwfs_pkg::hwfs_por ||
                   (!por_r && (state_r == hwfs_pkg::hwfs_ext ||
                    state_r == hwfs_pkg::hwfs_wake)))) begin
        o_flash_ready <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [6:0]              tick_seen_r;
  hwfs_pkg::hwfs_cnt_type  gap_r;
  hwfs_pkg::hwfs_cnt_type  por_gap_r;

  always_ff @(posedge i_core_clk) begin
    if (i_rst || (i_ce && wake_start)) begin
      tick_seen_r <= '0;
    end else if (i_ce && i_cpu_tick && tick_seen_r != 7'h7F) begin
      tick_seen_r <= tick_seen_r + 7'h01;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst || (i_ce && state_r == hwfs_pkg::hwfs_halt)) begin
      gap_r <= '0;
    end else if (i_ce && gap_r != '1) begin
      gap_r <= gap_r + 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst || (i_ce && state_r != hwfs_pkg::hwfs_por)) begin
      por_gap_r <= '0;
    end else if (i_ce && por_gap_r != '1) begin
      por_gap_r <= por_gap_r + 1'b1;
    end
  end

  a_wake_tick_count: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    $rose(o_cpu_run) |-> tick_seen_r >= 7'(`HWFS_WAKE_CYC))
    else $error("cpu restarted before 64 cpu ticks");

  a_flash_before_run: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    o_cpu_run |-> o_flash_ready)
    else $error("cpu running while flash not ready");

  a_flash_recovery_span: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    $rose(o_flash_ready) && !$past(por_r) |-> gap_r >= FLASH_CYC)
    else $error("flash ready before recovery time");

  a_por_extra_delay: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    $rose(o_cpu_run) && $past(state_r) == hwfs_pkg::hwfs_por
    |-> por_gap_r >= POR_CYC)
    else $error("power-on extra delay too short");

  a_int_rst_no_wait: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && o_cpu_run && state_r == hwfs_pkg::hwfs_run && i_int_rst
    |=> o_flash_ready [*8])
    else $error("internal reset dropped flash ready");

  a_run_both_done: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    $rose(o_cpu_run) |-> o_flash_ready
    && tick_seen_r >= 7'(`HWFS_WAKE_CYC))
    else $error("restart before both delays expired");

  c_halt_wake: cover property (@(posedge i_core_clk) disable iff (i_rst)
    $fell(o_clk_stopped) ##[1:1000] $rose(o_cpu_run));
  c_ext_rst_exit: cover property (@(posedge i_core_clk)
    disable iff (i_rst) o_clk_stopped && i_ext_rst);
  c_por_done: cover property (@(posedge i_core_clk) disable iff (i_rst)
    $fell(por_r));

endmodule

// ==== test_halt_wakeup_flash_ready_sequencer.sv ====
`timescale 1ns/1ps

module test_halt_wakeup_flash_ready_sequencer;
  localparam int FC = 100;
  localparam int PC = 30;

  typedef struct {
    int lo;
    int hi;
  } hwfs_note_type;

  logic          i_core_clk;
  logic          i_rst;
  logic          i_ce;
  logic          i_cpu_tick;
  logic          i_halt_req;
  logic          i_wake;
  logic          i_int_rst;
  logic          i_ext_rst;
  logic          o_cpu_run;
  logic          o_flash_ready;
  logic          o_clk_stopped;
  logic          run_q;
  hwfs_note_type notes[$];
  hwfs_note_type nt;
  int            n_errors;
  int            tests_run;
  int            cyc;
  int            t0;
  int            tick_p;
  int            tick_c;
  int            p;
  int            w;

  hwfs_sequencer #(
    .FLASH_CYC(FC),
    .POR_CYC  (PC)
  ) i_dut (
    .i_core_clk   (i_core_clk),
    .i_rst        (i_rst),
    .i_ce         (i_ce),
    .i_cpu_tick   (i_cpu_tick),
    .i_halt_req   (i_halt_req),
    .i_wake       (i_wake),
    .i_int_rst    (i_int_rst),
    .i_ext_rst    (i_ext_rst),
    .o_cpu_run    (o_cpu_run),
    .o_flash_ready(o_flash_ready),
    .o_clk_stopped(o_clk_stopped)
  );

  // ****************************************************************
  // clock and cpu tick marker
  // ****************************************************************
  initial begin
    i_core_clk = 1'h0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  always @(posedge i_core_clk) begin
    #1;
    tick_c = (tick_c + 1) % tick_p;
    i_cpu_tick = (tick_c == 0);
  end

  // ****************************************************************
  // checking
  // ****************************************************************
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // restart moment of the cpu is compared against the oldest note
  // sampled on the falling edge, away from the launching edge
  always @(negedge i_core_clk) begin
    cyc = cyc + 1;
    if (o_cpu_run === 1'h1 && run_q !== 1'h1) begin
      if (notes.size() == 0) begin
        check("run_note", 32'h0, 32'h1);
      end else begin
        nt = notes.pop_front();
        check("run_early", cyc - t0 >= nt.lo, 32'h1);
        check("run_late", cyc - t0 <= nt.hi, 32'h1);
        check("run_flash", o_flash_ready, 32'h1);
      end
    end
    run_q = o_cpu_run;
  end

  // ****************************************************************
  // stimulus tasks
  // ****************************************************************
  task automatic step(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  task automatic expect_run(input int lo, input int hi);
    hwfs_note_type n;
    n.lo = lo;
    n.hi = hi;
    notes.push_back(n);
    t0 = cyc;
  endtask

  task automatic wait_run();
    int k;
    k = 0;
    while (o_cpu_run !== 1'h1 && k < 2000) begin
      step(1);
      k++;
    end
    if (k >= 2000) begin
      n_errors++;
      complete_run();
    end
    step(2);
    check("run_stop", o_clk_stopped, 32'h0);
  endtask

  task automatic enter_halt();
    i_halt_req = 1'h1;
    step(1);
    i_halt_req = 1'h0;
    step(1);
    check("halt_stop", o_clk_stopped, 32'h1);
    check("halt_run", o_cpu_run, 32'h0);
    check("halt_flash", o_flash_ready, 32'h0);
    step(5);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {i_halt_req, i_wake, i_int_rst, i_ext_rst} = 4'h0;
    i_ce = 1'h1;
    i_rst = 1'h1;
    tick_p = 1;
    tick_c = 0;
    cyc = 0;
    n_errors = 0;
    tests_run = 0;
    p = $urandom(50);
    step(20);
    check("rst_out", {o_cpu_run, o_flash_ready, o_clk_stopped}, 32'h0);
    i_rst = 1'h0;
    expect_run(64 + PC - 1, 64 + PC + 8);
    wait_run();
    i_wake = 1'h1;
    step(1);
    i_wake = 1'h0;
    step(2);
    check("wake_in_run", o_cpu_run, 32'h1);
    for (int i = 0; i < 4; i++) begin
      p = (i == 0) ? 1 : 2 + $urandom % 3;
      tick_p = p;
      w = (64 * p > FC) ? 64 * p : FC;
      enter_halt();
      i_wake = 1'h1;
      expect_run(w - p, w + p + 6);
      step(1);
      i_wake = 1'h0;
      wait_run();
    end
    tick_p = 1;
    i_int_rst = 1'h1;
    step(2);
    check("irst_run", o_cpu_run, 32'h0);
    check("irst_flash", o_flash_ready, 32'h1);
    step(3);
    i_int_rst = 1'h0;
    expect_run(63, 72);
    wait_run();
    // short external pulse: flash timer must still gate the restart
    enter_halt();
    i_ext_rst = 1'h1;
    expect_run(FC - 1, FC + 8);
    step(20);
    i_ext_rst = 1'h0;
    wait_run();
    // external pulse held past the flash recovery time
    enter_halt();
    i_ext_rst = 1'h1;
    step(FC + 4);
    check("xrst_flash", o_flash_ready, 32'h1);
    check("xrst_run", o_cpu_run, 32'h0);
    i_ext_rst = 1'h0;
    expect_run(63, 72);
    wait_run();
    // clock enable low freezes every counter for w cycles
    w = 5 + $urandom % 20;
    enter_halt();
    i_wake = 1'h1;
    expect_run(FC - 1 + w, FC + 7 + w);
    step(1);
    i_wake = 1'h0;
    step(30);
    i_ce = 1'h0;
    step(w);
    check("ce_frozen", o_flash_ready, 32'h0);
    i_ce = 1'h1;
    wait_run();
    // reset in mid-run brings back the power-on path
    i_rst = 1'h1;
    step(3);
    check("rst2_out", {o_cpu_run, o_flash_ready, o_clk_stopped}, 32'h0);
    i_rst = 1'h0;
    expect_run(64 + PC - 1, 64 + PC + 8);
    wait_run();
    check("notes_left", notes.size(), 32'h0);
    complete_run();
  end
endmodule
